//--- src/bmrc_pkg.sv
// shared constants and types for the buck mode and retry control block
package bmrc_pkg;

  // ------------------------------------------------------------
  // register byte offsets
  // ------------------------------------------------------------
  localparam logic [11:0] BMRC_CTRL_OFS = 12'h000;
  localparam logic [11:0] BMRC_FREQ_OFS = 12'h004;
  localparam logic [11:0] BMRC_RETRY_OFS = 12'h008;
  localparam logic [11:0] BMRC_STAT_OFS = 12'h00C;

  // ------------------------------------------------------------
  // control register field positions
  // ------------------------------------------------------------
  localparam int BMRC_CTRL_EN_POS = 0;
  localparam int BMRC_CTRL_BYP_POS = 1;
  localparam int BMRC_CTRL_DIR_POS = 2;
  localparam int BMRC_CTRL_DONE_POS = 3;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [3:0] BMRC_CTRL_RST = 4'h0;
  localparam logic [2:0] BMRC_FREQ_RST = 3'h7;
  localparam logic [3:0] BMRC_RETRY_RST = 4'h4;

  // ------------------------------------------------------------
  // timing, at 250 MHz, period 4 ns
  // ------------------------------------------------------------
  localparam int BMRC_CLK_PS = 4000;
  localparam int BMRC_ONMAX_NS = 7500;
  localparam int BMRC_LSPULSE_NS = 60;
  localparam int BMRC_SOFTSTART_MS = 8;
  // longest times round down, least times round up
  localparam int BMRC_ONMAX_CYC = (BMRC_ONMAX_NS * 1000) / BMRC_CLK_PS;
  localparam int BMRC_LSPULSE_CYC = (BMRC_LSPULSE_NS * 1000 + BMRC_CLK_PS - 1) / BMRC_CLK_PS;
  localparam int BMRC_SOFTSTART_CYC = BMRC_SOFTSTART_MS * 250000;
  localparam logic [15:0] BMRC_VOUT_FULL = 16'h1F2E;
  localparam int BMRC_CNT_W = 32;

  // ------------------------------------------------------------
  // converter states
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    BMRC_OFF = 3'b000,
    BMRC_HOLD = 3'b001,
    BMRC_SOFT = 3'b010,
    BMRC_RUN = 3'b011,
    BMRC_WAIT_EN = 3'b100
  } bmrc_state_type;

endpackage

//--- src/bmrc_top.sv
// buck mode selection, soft-start, discharge and restart hold-off control
`timescale 1ns/1ps
// Behaviour
// - enable pin low at startup holds off
// - long on-time in run state forces short low-side pulses
// - soft-start ramps target to full over 8ms
// - any disable starts discharge and reset timer
// - reset timer running blocks restart
// - any fault resets the converter
// - fault clear starts programmable retry timer
// - permit low shuts down for hold-off time
// - detach shuts down for detach hold-off
// - three-bit frequency select, resets to fastest
// - standalone loads frequency from strap pin
// - clock output antiphase, forbids skip
// - clock input low or clocked forces pwm
// - clock input high: skip if bypass set
// - forced pwm switches at every load
// - attach leaves skip, stays pwm while attached
// - attach reported on pin, type-c attach also on status bit 7
// - bypass clear switches only when attached
// - skip only when all conditions hold
// - permit is enable pin and enable bit
// - after reset wait setup-done, and attach unless bypass set
module bmrc_top
  import bmrc_pkg::*;
#(
  parameter bit STANDALONE = 1'b0,
  parameter int DISCH_CYC = 250000,
  parameter int HOLD_CD_CYC = 250000,
  parameter int HOLD_DET_CYC = 250000,
  parameter int RETRY_UNIT_CYC = 250000,
  parameter int SOFT_CYC = BMRC_SOFTSTART_CYC
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // enables and straps
  input wire logic system_enable_pin,
  input wire logic buck_enable_pin,
  input wire logic [1:0] frequency_strap_pin,
  // type-c and attach inputs
  input wire logic typec_attached,
  input wire logic typec_detach,
  input wire logic charger_auto_mode,
  input wire logic dcp_attach,
  input wire logic sense_attach,
  // faults, level while present
  input wire logic fault_uv,
  input wire logic fault_ov,
  input wire logic fault_oc,
  input wire logic fault_ot,
  // power stage feedback and oscillator
  input wire logic high_side_on,
  input wire logic osc_clk,
  // external clock pin, two-way
  input wire logic ext_clk_i,
  input wire logic ext_clk_activity,
  output logic ext_clk_o,
  output logic ext_clk_oe,
  // converter controls
  output logic converter_on,
  output logic force_low_side,
  output logic [15:0] vout_target,
  output logic discharge_current,
  output logic fixed_frequency_mode,
  output logic [2:0] frequency_select_field,
  output logic attach_pin
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] ctrl;          // enable, bypass, direction, done
    logic [2:0] freq;          // oscillator select
    logic [3:0] retry;         // retry length in units, less one
    logic [31:0] rdata;        // registered read data
    bmrc_state_type st;        // converter state
    logic [BMRC_CNT_W-1:0] tmr; // hold-off or ramp counter
    logic [BMRC_CNT_W-1:0] ontm; // on-time counter
    logic [7:0] lsp;           // low-side pulse counter
    logic fault_d;             // fault seen last cycle
    logic permit_d;            // permit last cycle
    logic strap_done;          // strap captured after reset
    logic started;             // left startup hold
    logic [15:0] vt;           // soft-start target
    logic vout_dis;            // discharge active
    logic holdoff;             // restart timer running
  } bmrc_regs_type;

  // whole block state, the registered copy and its next value
  bmrc_regs_type s_r;
  bmrc_regs_type s_nxt;

  // glue terms shared by several branches
  logic permit;        // combined enable
  logic fault_any;     // any fault level
  logic skip_ok;       // skip conditions all met
  logic apb_wr;        // write access phase
  logic apb_rd;        // read access phase
  logic mapped;        // address hits a register

  // ------------------------------------------------------------
  // combinational terms
  // ------------------------------------------------------------
  // permit from pin and bit
  assign permit = buck_enable_pin & s_r.ctrl[BMRC_CTRL_EN_POS];
  assign fault_any = fault_uv | fault_ov | fault_oc | fault_ot;
  assign skip_ok = s_r.ctrl[BMRC_CTRL_BYP_POS] & ~s_r.ctrl[BMRC_CTRL_DIR_POS] & ext_clk_i
                   & ~ext_clk_activity & charger_auto_mode & ~dcp_attach & ~sense_attach;
  // access phase decodes, the setup phase alone has no effect
  assign apb_wr = psel & penable & pwrite;
  assign apb_rd = psel & penable & ~pwrite;
  assign mapped = (paddr == BMRC_CTRL_OFS) | (paddr == BMRC_FREQ_OFS)
                  | (paddr == BMRC_RETRY_OFS) | (paddr == BMRC_STAT_OFS);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // later assignments override earlier ones, so the order of the
  // blocks below sets the priority: system enable beats faults
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.fault_d = fault_any;
    s_nxt.permit_d = permit;
    // register writes, single cycle access
    if (apb_wr)
    begin
      // status is read-only, so writes to it fall through
      if (paddr == BMRC_CTRL_OFS)
      begin
        s_nxt.ctrl = pwdata[3:0];
      end
      else if (paddr == BMRC_FREQ_OFS && !STANDALONE)
      begin
        s_nxt.freq = pwdata[2:0];
      end
      else if (paddr == BMRC_RETRY_OFS)
      begin
        s_nxt.retry = pwdata[3:0];
      end
    end
    // strap loaded once after reset, four choices
    if (STANDALONE && !s_r.strap_done)
    begin
      s_nxt.freq = {frequency_strap_pin, 1'b1};
      s_nxt.strap_done = 1'b1;
    end
    // read data decoded from paddr every cycle, in any phase
    s_nxt.rdata = 32'h0000_0000;
    case (paddr)
      BMRC_CTRL_OFS: s_nxt.rdata = {28'h0, s_r.ctrl};
      BMRC_FREQ_OFS: s_nxt.rdata = {29'h0, s_r.freq};
      BMRC_RETRY_OFS: s_nxt.rdata = {28'h0, s_r.retry};
      BMRC_STAT_OFS: s_nxt.rdata = {24'h0, typec_attached, fault_any, s_r.holdoff,
                                    s_r.vout_dis, 1'b0, s_r.st};
      // unmapped offsets read as zero
      default: s_nxt.rdata = 32'h0000_0000;
    endcase
    // on-time watchdog with forced low-side pulse
    // count held at zero during a pulse, so pulses repeat each window
    if (s_r.lsp != 8'h00)
    begin
      s_nxt.lsp = s_r.lsp - 8'h01;
      s_nxt.ontm = '0;
    end
    else if (high_side_on && s_r.st == BMRC_RUN)
    begin
      if (s_r.ontm >= BMRC_CNT_W'(BMRC_ONMAX_CYC - 1))
      begin
        s_nxt.ontm = '0;
        s_nxt.lsp = 8'(BMRC_LSPULSE_CYC);
      end
      else
      begin
        s_nxt.ontm = s_r.ontm + 1'b1;
      end
    end
    else
    begin
      s_nxt.ontm = '0;
    end
    // converter sequencing
    // one shared counter counts down for every hold-off and up for the ramp
    if (s_r.tmr != '0)
    begin
      s_nxt.tmr = s_r.tmr - 1'b1;
    end
    case (s_r.st)
      // startup wait for enable pin high
      BMRC_WAIT_EN:
      begin
        s_nxt.vt = 16'h0000;
        if (system_enable_pin && buck_enable_pin)
        begin
          // a discharge timer still running must expire first
          s_nxt.st = (s_r.tmr != '0) ? BMRC_HOLD : BMRC_OFF;
        end
      end
      BMRC_OFF:
      begin
        s_nxt.vt = 16'h0000;
        s_nxt.vout_dis = 1'b0;
        if (permit && !fault_any && s_r.ctrl[BMRC_CTRL_DONE_POS]
            && (typec_attached || s_r.ctrl[BMRC_CTRL_BYP_POS]))
        begin
          s_nxt.st = BMRC_SOFT;
          s_nxt.tmr = '0;
        end
      end
      BMRC_HOLD:
      begin
        s_nxt.vt = 16'h0000;
        if (s_r.tmr == '0)
        begin
          s_nxt.st = BMRC_OFF;
        end
      end
      // linear ramp of target to full
      BMRC_SOFT:
      begin
        s_nxt.tmr = s_r.tmr + 1'b1;
        // full code times a long ramp count overflows 32 bits, so go wide
        s_nxt.vt = 16'((64'(BMRC_VOUT_FULL) * 64'(s_r.tmr)) / 64'(SOFT_CYC));
        if (s_r.tmr >= BMRC_CNT_W'(SOFT_CYC - 1))
        begin
          s_nxt.st = BMRC_RUN;
          s_nxt.vt = BMRC_VOUT_FULL;
          s_nxt.tmr = '0;
        end
      end
      // steady state, left only through the shutdown checks below
      BMRC_RUN:
      begin
        s_nxt.vt = BMRC_VOUT_FULL;
      end
      // unused codes fall back to off
      default:
      begin
        s_nxt.st = BMRC_OFF;
      end
    endcase
    // flag follows the hold state, the shutdown paths below set it too
    s_nxt.holdoff = (s_nxt.st == BMRC_HOLD);
    // shutdown causes, later ones override the timer of earlier ones
    if (s_r.st == BMRC_SOFT || s_r.st == BMRC_RUN)
    begin
      // discharge and reset timer on disable
      if (!permit || fault_any || typec_detach
          || (!typec_attached && !s_r.ctrl[BMRC_CTRL_BYP_POS]))
      begin
        s_nxt.st = BMRC_HOLD;
        s_nxt.vout_dis = 1'b1;
        s_nxt.vt = 16'h0000;
        s_nxt.tmr = BMRC_CNT_W'(DISCH_CYC);
        s_nxt.holdoff = 1'b1;
      end
      if (!permit)
      begin
        s_nxt.tmr = BMRC_CNT_W'(HOLD_CD_CYC);
      end
      if (typec_detach)
      begin
        s_nxt.tmr = BMRC_CNT_W'(HOLD_DET_CYC);
      end
    end
    // fault holds converter in reset
    // while the fault stands the discharge timer counts down and reloads each time it reaches zero
    if (fault_any && s_r.st != BMRC_WAIT_EN)
    begin
      s_nxt.st = BMRC_HOLD;
      s_nxt.vout_dis = 1'b1;
      s_nxt.holdoff = 1'b1;
      s_nxt.tmr = (s_r.tmr > 0) ? s_nxt.tmr : BMRC_CNT_W'(DISCH_CYC);
    end
    // retry timer starts when fault clears
    else if (s_r.fault_d && s_r.st != BMRC_WAIT_EN)
    begin
      s_nxt.st = BMRC_HOLD;
      s_nxt.holdoff = 1'b1;
      s_nxt.tmr = BMRC_CNT_W'((32'(s_r.retry) + 32'd1) * RETRY_UNIT_CYC);
    end
    // system enable low returns to startup wait
    if (!system_enable_pin)
    begin
      s_nxt.st = BMRC_WAIT_EN;
      s_nxt.vt = 16'h0000;
      // a running converter still discharges on this path
      if (s_r.st == BMRC_SOFT || s_r.st == BMRC_RUN)
      begin
        s_nxt.vout_dis = 1'b1;
        s_nxt.tmr = BMRC_CNT_W'(DISCH_CYC);
      end
      // any timer already running keeps counting in the startup wait
    end
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  // all timers reset to idle counts
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r.ctrl <= BMRC_CTRL_RST;
      s_r.freq <= BMRC_FREQ_RST;
      s_r.retry <= BMRC_RETRY_RST;
      s_r.rdata <= 32'h0000_0000;
      s_r.st <= BMRC_WAIT_EN;
      s_r.tmr <= '0;
      s_r.ontm <= '0;
      s_r.lsp <= 8'h00;
      s_r.fault_d <= 1'b0;
      s_r.permit_d <= 1'b0;
      s_r.strap_done <= 1'b0;
      s_r.started <= 1'b0;
      s_r.vt <= 16'h0000;
      s_r.vout_dis <= 1'b0;
      s_r.holdoff <= 1'b0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // zero wait states, read data taken in access phase
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  // read data gated to zero outside the read access phase
  assign prdata = s_nxt.rdata & {32{apb_rd}};
  // converter switches only in the ramp and run states
  assign converter_on = (s_r.st == BMRC_SOFT) | (s_r.st == BMRC_RUN);
  // pulse counter nonzero turns the low side on
  assign force_low_side = (s_r.lsp != 8'h00);
  // target, discharge and select straight from flip-flops
  assign vout_target = s_r.vt;
  assign discharge_current = s_r.vout_dis;
  assign frequency_select_field = s_r.freq;
  assign ext_clk_oe = s_r.ctrl[BMRC_CTRL_DIR_POS];
  assign ext_clk_o = ~osc_clk & s_r.ctrl[BMRC_CTRL_DIR_POS];
  assign fixed_frequency_mode = ~skip_ok;
  assign attach_pin = typec_attached | dcp_attach | sense_attach;

endmodule

//--- dv/bmrc_props.sv
// checker for buck mode and retry control
`timescale 1ns/1ps
module bmrc_props
  import bmrc_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // watched inputs
  input wire logic buck_enable_pin,
  input wire logic typec_detach,
  input wire logic charger_auto_mode,
  input wire logic dcp_attach,
  input wire logic sense_attach,
  input wire logic fault_uv,
  input wire logic fault_ov,
  input wire logic fault_oc,
  input wire logic fault_ot,
  input wire logic osc_clk,
  input wire logic ext_clk_i,
  input wire logic ext_clk_activity,
  // watched outputs
  input wire logic ext_clk_o,
  input wire logic ext_clk_oe,
  input wire logic converter_on,
  input wire logic force_low_side,
  input wire logic discharge_current,
  input wire logic fixed_frequency_mode,
  input wire logic attach_pin
);
  // any fault level present
  wire logic any_fault = fault_uv | fault_ov | fault_oc | fault_ot;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_pin_low;
    !buck_enable_pin ##1 !buck_enable_pin |-> !converter_on;
  endproperty
  a_pin_low: assert property (p_pin_low) else $error("converter on with enable pin low");
  property p_permit;
    converter_on && !buck_enable_pin |=> !converter_on;
  endproperty
  a_permit: assert property (p_permit) else $error("no shutdown on permit low");
  property p_fault;
    converter_on && any_fault |=> !converter_on;
  endproperty
  a_fault: assert property (p_fault) else $error("no shutdown on fault");
  property p_detach;
    converter_on && typec_detach |=> !converter_on;
  endproperty
  a_detach: assert property (p_detach) else $error("no shutdown on detach");
  property p_disch;
    $fell(converter_on) |-> ##[0:1] discharge_current;
  endproperty
  a_disch: assert property (p_disch) else $error("no discharge after disable");
  property p_block;
    discharge_current |-> !converter_on;
  endproperty
  a_block: assert property (p_block) else $error("restart during discharge");
  property p_lspulse;
    $rose(force_low_side) |-> force_low_side[*8];
  endproperty
  a_lspulse: assert property (p_lspulse) else $error("low-side pulse too short");
  property p_clk_out;
    ext_clk_oe |-> fixed_frequency_mode && (ext_clk_o == !osc_clk);
  endproperty
  a_clk_out: assert property (p_clk_out) else $error("clock output wrong");
  property p_clk_in;
    !ext_clk_oe && (!ext_clk_i || ext_clk_activity) |-> fixed_frequency_mode;
  endproperty
  a_clk_in: assert property (p_clk_in) else $error("skip with low or clocked pin");
  property p_skip;
    !fixed_frequency_mode |-> ext_clk_i && charger_auto_mode && !dcp_attach && !sense_attach;
  endproperty
  a_skip: assert property (p_skip) else $error("skip without all conditions");
  property p_attach;
    dcp_attach || sense_attach |-> attach_pin;
  endproperty
  a_attach: assert property (p_attach) else $error("attach not reported");
endmodule
bind bmrc_top bmrc_props u_bmrc_props (.pclk, .presetn, .buck_enable_pin, .typec_detach,
  .charger_auto_mode, .dcp_attach, .sense_attach, .fault_uv, .fault_ov, .fault_oc, .fault_ot,
  .osc_clk, .ext_clk_i, .ext_clk_activity, .ext_clk_o, .ext_clk_oe, .converter_on,
  .force_low_side, .discharge_current, .fixed_frequency_mode, .attach_pin);

//--- dv/bmrc_load_model.sv
// usb port load: attach level and detach pulse
`timescale 1ns/1ps
module bmrc_load_model
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // plug state from the bench
  input wire logic plug,
  // cc side signals
  output logic typec_attached,
  output logic typec_detach
);
  // detach is one cycle, on the unplug edge only
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      typec_attached <= 1'b0;
      typec_detach <= 1'b0;
    end
    else
    begin
      typec_attached <= plug;
      typec_detach <= typec_attached & ~plug;
    end
  end
endmodule

//--- dv/test_buck_mode_and_retry_control.sv
// bench for buck mode and retry control
`timescale 1ns/1ps
module test_buck_mode_and_retry_control;
  import bmrc_pkg::*;
  // short timer lengths, distinct to catch swaps except DIS and RU, both 20
  localparam int HCD = 30, HDT = 50, DIS = 20, RU = 20, SC = 64;
  logic pclk = 1'b0, presetn = 1'b0, osc_clk = 1'b0, plug = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, ext_clk_o, ext_clk_oe, converter_on, force_low_side;
  logic sys_en = 1'b0, buck_en = 1'b0, auto_m = 1'b0, dcp = 1'b0, sns = 1'b0;
  logic f_uv = 1'b0, f_ov = 1'b0, hs_on = 1'b0, ck_i = 1'b0, ck_act = 1'b0;
  logic attached, detach, disch, ffm, attach_pin;
  logic [15:0] vout;
  logic [2:0] fsel;
  int mismatches = 0, comparisons = 0, n_cyc;
  always #2 pclk = ~pclk;
  // oscillator toggles on falling pclk edges only, never on rising ones
  always #4 osc_clk = ~osc_clk;
  bmrc_top #(.DISCH_CYC(DIS), .HOLD_CD_CYC(HCD), .HOLD_DET_CYC(HDT), .RETRY_UNIT_CYC(RU),
    .SOFT_CYC(SC)) u_bmrc_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .system_enable_pin(sys_en), .buck_enable_pin(buck_en),
    .frequency_strap_pin(2'h0), .typec_attached(attached), .typec_detach(detach),
    .charger_auto_mode(auto_m), .dcp_attach(dcp), .sense_attach(sns), .fault_uv(f_uv),
    .fault_ov(f_ov), .fault_oc(1'b0), .fault_ot(1'b0), .high_side_on(hs_on), .osc_clk,
    .ext_clk_i(ck_i), .ext_clk_activity(ck_act), .ext_clk_o, .ext_clk_oe, .converter_on,
    .force_low_side, .vout_target(vout), .discharge_current(disch),
    .fixed_frequency_mode(ffm), .frequency_select_field(fsel), .attach_pin);
  bmrc_load_model u_bmrc_load_model (.pclk, .presetn, .plug, .typec_attached(attached),
    .typec_detach(detach));
  task wrap_up();
    $display("mismatches %0d comparisons %0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  // one apb transfer; waits for pready, bounded
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
      if (n > 20)
      begin
        mismatches++;
        wrap_up();
      end
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // count cycles until converter_on or force_low_side reaches v
  task wt(input logic sel, input logic v, input int lim);
    n_cyc = 0;
    while ((sel ? force_low_side : converter_on) !== v)
    begin
      @(posedge pclk);
      n_cyc++;
      if (n_cyc > lim)
      begin
        mismatches++;
        wrap_up();
      end
    end
  endtask
  task t_regs();
    apb(0, BMRC_CTRL_OFS, 0);
    chk(rd, BMRC_CTRL_RST);
    apb(0, BMRC_FREQ_OFS, 0);
    chk(rd, 32'h7);
    apb(0, BMRC_RETRY_OFS, 0);
    chk(rd, BMRC_RETRY_RST);
    apb(0, 12'h010, 0);
    chk(er, 1'b1);
    apb(1, BMRC_FREQ_OFS, 32'h2);
    apb(0, BMRC_FREQ_OFS, 0);
    chk(rd, 32'h2);
    chk(fsel, 3'h2);
    apb(1, BMRC_RETRY_OFS, 32'h1);
  endtask
  task t_start();
    sys_en <= 1'b1;
    apb(1, BMRC_CTRL_OFS, 32'hB);
    repeat (40) @(posedge pclk);
    chk(converter_on, 1'b0);
    apb(1, BMRC_CTRL_OFS, 32'h3);
    buck_en <= 1'b1;
    repeat (40) @(posedge pclk);
    chk(converter_on, 1'b0);
    apb(1, BMRC_CTRL_OFS, 32'hB);
    wt(0, 1, 20);
    apb(0, BMRC_STAT_OFS, 0);
    chk(rd[2:0], 3'h2);
    repeat (SC) @(posedge pclk);
    apb(0, BMRC_STAT_OFS, 0);
    chk(rd[2:0], 3'h3);
    chk(vout, BMRC_VOUT_FULL);
  endtask
  task t_lsp();
    hs_on <= 1'b1;
    wt(1, 1, 2000);
    chk(n_cyc >= 1874 && n_cyc <= 1877, 1);
    wt(1, 0, 40);
    chk(n_cyc, 15);
    hs_on <= 1'b0;
  endtask
  // k: 0 permit low, 1 detach, 2 fault; e: expected off time
  task t_off(input int k, input int e);
    case (k)
      0: buck_en <= 1'b0;
      1: plug <= 1'b0;
      default: f_ov <= 1'b1;
    endcase
    wt(0, 0, 5);
    @(posedge pclk);
    chk(disch, 1'b1);
    repeat (10) @(posedge pclk);
    chk(converter_on, 1'b0);
    buck_en <= 1'b1;
    plug <= 1'b1;
    f_ov <= 1'b0;
    wt(0, 1, e + 60);
    n_cyc = n_cyc + ((k == 2) ? 0 : 11);
    chk(n_cyc >= e && n_cyc <= e + 6, 1);
    repeat (SC + 4) @(posedge pclk);
  endtask
  task t_mode();
    plug <= 1'b0;
    ck_i <= 1'b1;
    auto_m <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(ffm, 1'b0);
    for (int i = 0; i < 5; i++)
    begin
      ck_i <= (i != 0);
      // activity level stands for a clock inside the lock window
      ck_act <= (i == 1);
      auto_m <= (i != 2);
      dcp <= (i == 3);
      sns <= (i == 4);
      repeat (2) @(posedge pclk);
      chk(ffm, 1'b1);
      chk(attach_pin, i >= 3);
    end
    sns <= 1'b0;
    apb(1, BMRC_CTRL_OFS, 32'hF);
    @(posedge pclk);
    chk(ffm, 1'b1);
    chk(ext_clk_oe, 1'b1);
    chk(ext_clk_o, !osc_clk);
    apb(1, BMRC_CTRL_OFS, 32'h9);
    repeat (SC) @(posedge pclk);
    chk(ffm, 1'b1);
    chk(converter_on, 1'b0);
    plug <= 1'b1;
    wt(0, 1, 200);
    chk(converter_on, 1'b1);
    apb(0, BMRC_STAT_OFS, 0);
    chk(rd[7], 1'b1);
  endtask
  // system enable drop while ramping: discharge, then hold-off on return
  task t_sysoff();
    sys_en <= 1'b0;
    wt(0, 0, 5);
    @(posedge pclk);
    chk(disch, 1'b1);
    sys_en <= 1'b1;
    wt(0, 1, DIS + 20);
    chk(n_cyc >= DIS - 3 && n_cyc <= DIS + 3, 1);
  endtask
  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_start();
    t_lsp();
    t_off(0, HCD);
    t_off(2, 2 * RU);
    t_off(1, HDT);
    t_mode();
    t_sysoff();
    wrap_up();
  end
endmodule
